// >>> dv/accel_pid_bench.sv
// Self-checking bench for the acceleration hold and process PID block.
`timescale 1ns/1ps
module accel_pid_bench;
   // ----------------------------------------------------------------
   // Stimulus and design
   // ----------------------------------------------------------------
   localparam int TICK = 10;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic start = 1'b0;
   logic byp = 1'b0;
   logic [15:0] freq_cmd = 16'h1b58;
   logic [15:0] step = 16'h2710;
   logic [1:0] curve = 2'h0;
   logic [15:0] hold_f = 16'h0000;
   logic [9:0] hold_d = 10'h001;
   logic [15:0] max_f = 16'h2710;
   logic [15:0] sp = 16'h1388;
   logic [3:0] fb_src = 4'h2;
   logic [15:0] fb_level = 16'h07d0;
   logic [15:0] ff_level = 16'h01f4;
   accel_pid_pkg::pid_cfg_t cfg = '{2'h1, 6'h0a, 16'h8ca0, 14'h0, 14'h0064, 4'h2, 1'b0, 10'h0, 2'h0, 10'h0,
      10'h064, 10'h12c};
   accel_pid_pkg::analog_in_t analog;
   logic [15:0] freq_out;
   logic hold_active;
   logic [1:0] act_curve;
   logic [19:0] pv;
   logic dev_alarm;
   logic fb_cmp;
   int n_mismatch = 0;
   int check_count = 0;
   int cycles = 0;
   always #5 ref_clk = ~ref_clk;
   accel_pid #(.TICK_CYCLES(TICK)) accel_pid_inst (.REF_CLK(ref_clk), .SRST(srst), .START(start),
      .FREQ_CMD(freq_cmd), .ACCEL_STEP(step), .ACCEL_CURVE_SELECT(curve), .ACCEL_HOLD_FREQUENCY(hold_f),
      .ACCEL_HOLD_DURATION(hold_d), .PID_DISABLE_TERMINAL(byp), .MAX_FREQ(max_f), .SETPOINT(sp),
      .PID_CONFIG(cfg), .ANALOG_IN(analog), .FREQ_OUT(freq_out), .HOLD_ACTIVE(hold_active),
      .ACTIVE_CURVE(act_curve), .PROCESS_VALUE(pv), .DEVIATION_ALARM_OUTPUT(dev_alarm),
      .FEEDBACK_COMPARE_OUTPUT(fb_cmp));
   accel_pid_sensor_model accel_pid_sensor_model_inst (.fb_src(fb_src), .fb_level(fb_level),
      .ff_level(ff_level), .analog(analog));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [19:0] got, input logic [19:0] exp, input logic [19:0] tol, input string what);
      check_count++;
      if (!((^got !== 1'bx) && got + tol >= exp && got <= exp + tol)) begin
         n_mismatch++;
         $display("[FAIL] %0t %s got %0d expected %0d", $time, what, got, exp);
      end
   endtask
   task automatic ticks(input int n);
      repeat (n * TICK + 2) @(posedge ref_clk);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         test_done();
      end
   end
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic test_hold(input logic [1:0] c);
      int n;
      start <= 1'b0;
      curve <= c;
      cfg.pid_enable_select <= accel_pid_pkg::PID_OFF;
      repeat (3) @(posedge ref_clk);
      start <= 1'b1;
      n = 0;
      while (freq_out !== 16'h0cb2 && n < 400) begin
         @(posedge ref_clk);
         n++;
         if (freq_out > 16'h0cb2) check({4'h0, freq_out}, 20'h00cb2, 20'h0, "ramp passed hold");
      end
      check({4'h0, freq_out}, 20'h00cb2, 20'h0, "hold reached");
      ticks(90);
      check({4'h0, freq_out}, 20'h00cb2, 20'h0, "hold kept");
      check({19'h0, hold_active}, 20'h1, 20'h0, "hold flag");
      check({18'h0, act_curve}, {18'h0, c}, 20'h0, "curve echo");
      ticks(40);
      check({4'h0, freq_out}, 20'h02710, 20'h0, "ramp resumed");
      $display("test_hold done");
   endtask
   task automatic pid_case(input logic [1:0] mode, input logic inv, input logic [5:0] kp, input logic [15:0] ti,
      input logic [15:0] s, input logic [9:0] rng, input logic [1:0] ff, input logic b, input logic [15:0] exp);
      cfg.pid_enable_select <= mode;
      cfg.deviation_invert <= inv;
      cfg.proportional_gain <= kp;
      cfg.integral_time <= ti;
      cfg.variation_range <= rng;
      cfg.feedforward_select <= ff;
      sp <= s;
      byp <= b;
      ticks(20);
      check({4'h0, freq_out}, {4'h0, exp}, 20'h3, "pid result");
   endtask
   task automatic test_pid();
      start <= 1'b0;
      hold_f <= 16'h0000;
      step <= 16'h2710;
      freq_cmd <= 16'h1b58;
      repeat (3) @(posedge ref_clk);
      start <= 1'b1;
      pid_case(2'h0, 1'b0, 6'h0a, 16'h8ca0, 16'h1388, 10'h0, 2'h0, 1'b0, 16'h1b58);
      pid_case(2'h1, 1'b0, 6'h0a, 16'h8ca0, 16'h1388, 10'h0, 2'h0, 1'b0, 16'h0bb8);
      pid_case(2'h1, 1'b0, 6'h0a, 16'h8ca0, 16'h1770, 10'h0, 2'h0, 1'b0, 16'h0fa0);
      pid_case(2'h1, 1'b0, 6'h14, 16'h8ca0, 16'h1388, 10'h0, 2'h0, 1'b0, 16'h1770);
      pid_case(2'h1, 1'b1, 6'h0a, 16'h8ca0, 16'h1388, 10'h0, 2'h0, 1'b0, 16'h0000);
      pid_case(2'h2, 1'b1, 6'h0a, 16'h8ca0, 16'h1388, 10'h0, 2'h0, 1'b0, 16'h0bb8);
      pid_case(2'h1, 1'b0, 6'h0a, 16'h8ca0, 16'h1388, 10'h064, 2'h0, 1'b0, 16'h0fa0);
      pid_case(2'h2, 1'b1, 6'h0a, 16'h8ca0, 16'h1388, 10'h064, 2'h0, 1'b0, 16'h0bb8);
      pid_case(2'h1, 1'b0, 6'h0a, 16'h0000, 16'h1388, 10'h0, 2'h0, 1'b0, 16'h0000);
      for (int f = 1; f < 4; f++) begin
         pid_case(2'h1, 1'b0, 6'h0a, 16'h8ca0, 16'h1388, 10'h0, f[1:0], 1'b0, 16'h0dac);
      end
      max_f <= 16'h4e20;
      pid_case(2'h1, 1'b0, 6'h0a, 16'h8ca0, 16'h1388, 10'h0, 2'h0, 1'b0, 16'h1770);
      max_f <= 16'h2710;
      pid_case(2'h1, 1'b0, 6'h0a, 16'h8ca0, 16'h1388, 10'h0, 2'h0, 1'b1, 16'h1b58);
      byp <= 1'b0;
      $display("test_pid done");
   endtask
   task automatic test_levels();
      logic [15:0] lv [6] = '{16'h01f4, 16'h0bb7, 16'h0bb8, 16'h03e9, 16'h03e8, 16'h07d0};
      logic ex [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
      logic [3:0] src [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'ha};
      for (int i = 0; i < 6; i++) begin
         fb_level <= lv[i];
         repeat (3) @(posedge ref_clk);
         check({19'h0, fb_cmp}, {19'h0, ex[i]}, 20'h0, "compare output");
      end
      cfg.deviation_alarm_level <= 10'h12b;
      repeat (3) @(posedge ref_clk);
      check({19'h0, dev_alarm}, 20'h1, 20'h0, "alarm above level");
      cfg.deviation_alarm_level <= 10'h12c;
      repeat (3) @(posedge ref_clk);
      check({19'h0, dev_alarm}, 20'h0, 20'h0, "alarm at level");
      for (int i = 0; i < 5; i++) begin
         fb_src <= src[i];
         cfg.feedback_source_select <= src[i];
         repeat (3) @(posedge ref_clk);
         check(pv, 20'h007d0, 20'h0, "feedback source");
      end
      cfg.feedback_scale <= 14'h270f;
      repeat (3) @(posedge ref_clk);
      check(pv, 20'h30d2c, 20'h0, "scale max");
      cfg.feedback_scale <= 14'h00fa;
      repeat (3) @(posedge ref_clk);
      check(pv, 20'h01388, 20'h0, "scale mid");
      $display("test_levels done");
   endtask
   initial begin
      repeat (12) @(posedge ref_clk);
      srst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      check({4'h0, freq_out}, 20'h0, 20'h0, "freq after reset");
      check({19'h0, hold_active}, 20'h0, 20'h0, "hold after reset");
      step <= 16'h01f4;
      hold_f <= 16'h0cb2;
      freq_cmd <= 16'h2710;
      for (int c = 0; c < 4; c++) begin
         test_hold(c[1:0]);
      end
      test_pid();
      test_levels();
      test_done();
   end
endmodule

// >>> dv/accel_pid_sensor_model.sv
// Process sensor model that feeds the feedback and feed forward channels.
`timescale 1ns/1ps
module accel_pid_sensor_model (
   input wire logic [3:0] fb_src,
   input wire logic [15:0] fb_level,
   input wire logic [15:0] ff_level,
   output accel_pid_pkg::analog_in_t analog
);
   // ----------------------------------------------------------------
   // Channels
   // ----------------------------------------------------------------
   // Unselected channels carry a different level, so a wrong channel pick changes the result.
   always_comb begin
      analog.current_input = (fb_src == accel_pid_pkg::FB_CURRENT) ? fb_level : ff_level;
      analog.voltage_input = (fb_src == accel_pid_pkg::FB_VOLTAGE) ? fb_level : ff_level;
      analog.serial_feedback = (fb_src == accel_pid_pkg::FB_SERIAL) ? fb_level : ff_level;
      analog.pulse_feedback = (fb_src == accel_pid_pkg::FB_PULSE) ? fb_level : ff_level;
      analog.arith_result = (fb_src == accel_pid_pkg::FB_ARITH) ? fb_level : ff_level;
      analog.bipolar_voltage_input = {1'b0, ff_level};
   end
endmodule

// >>> verilog/accel_pid.sv
// Start-up acceleration hold and process PID loop of the inverter control path.
`timescale 1ns/1ps
// Operation
// - Acceleration stops rising at the hold frequency, 0.00 to 400.0 Hz.
// - Output stays at hold frequency for hold duration, 0.0 to 60.0 s.
// - Hold works with every acceleration curve shape.
// - PID enable: 00 off, 01 on, 02 on with negative results inverted.
// - PID disable terminal asserted drives the normal frequency command.
// - Proportional gain ranges 0.2 to 5.0.
// - Integral time ranges 0.0 to 3600 s.
// - Derivative time ranges 0.00 to 100.0 s.
// - Reported feedback is multiplied by scale 0.01 to 99.99.
// - Feedback source: 00 current, 01 voltage, 02 serial, 03 pulse, 10 arithmetic.
// - Deviation inversion 01 negates setpoint minus feedback; 00 keeps it.
// - Variation range 0.0 to 100.0 percent around the setpoint.
// - Feed forward: 00 none, 01 voltage, 02 current, 03 bipolar input.
// - Deviation alarm threshold settable 0.0 to 100.0 percent.
// - Feedback compare output uses separate on and off thresholds.
// - Proportional path follows setpoint changes in direct proportion.
// - Absolute deviation above alarm threshold asserts the deviation alarm.
// - Negative result clamps to zero, or is negated in inverted mode.
// - Output limited to setpoint plus or minus range with PID enable 01 only; zero range disables.
module accel_pid #(
   parameter int TICK_CYCLES = accel_pid_pkg::TICK_CYCLES
) (
   input wire logic REF_CLK,
   input wire logic SRST,
   input wire logic START,
   input wire logic [15:0] FREQ_CMD,
   input wire logic [15:0] ACCEL_STEP,
   input wire logic [1:0] ACCEL_CURVE_SELECT,
   input wire logic [15:0] ACCEL_HOLD_FREQUENCY,
   input wire logic [9:0] ACCEL_HOLD_DURATION,
   input wire logic PID_DISABLE_TERMINAL,
   input wire logic [15:0] MAX_FREQ,
   input wire logic [15:0] SETPOINT,
   input wire accel_pid_pkg::pid_cfg_t PID_CONFIG,
   input wire accel_pid_pkg::analog_in_t ANALOG_IN,
   output logic [15:0] FREQ_OUT,
   output logic HOLD_ACTIVE,
   output logic [1:0] ACTIVE_CURVE,
   output logic [19:0] PROCESS_VALUE,
   output logic DEVIATION_ALARM_OUTPUT,
   output logic FEEDBACK_COMPARE_OUTPUT
);
   default clocking ctrl_cb @(posedge REF_CLK);
   endclocking
   default disable iff (SRST);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic signed [47:0] sat(input logic signed [47:0] v, input logic signed [47:0] lo,
                                              input logic signed [47:0] hi);
      sat = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   typedef enum logic [2:0] {
      ST_STOP = 3'h1,
      ST_RAMP = 3'h2,
      ST_HOLD = 3'h4
   } ramp_state_t;

   ramp_state_t state;
   logic [16:0] tick_cnt;
   logic tick;
   logic held;
   logic [15:0] hold_ms;
   logic signed [47:0] acc;
   logic signed [16:0] e_prev;
   logic [15:0] pid_pct;
   logic [15:0] hold_f;
   logic [15:0] hold_limit;
   logic [15:0] fb;
   logic signed [16:0] ff;
   logic signed [16:0] dev;
   logic signed [16:0] dev_abs;
   logic [5:0] kp;
   logic [15:0] ti;
   logic [13:0] td;
   logic pid_active;
   logic signed [47:0] p_term;
   logic signed [47:0] i_term;
   logic signed [47:0] d_term;
   logic signed [47:0] u;
   logic signed [47:0] next_pct;
   logic [15:0] pid_freq;
   logic [15:0] target;

   // ----------------------------------------------------------------
   // Millisecond control tick
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (SRST || tick_cnt == 17'(TICK_CYCLES - 1)) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= tick_cnt + 17'h00001;
      end
      tick <= !SRST && tick_cnt == 17'(TICK_CYCLES - 1);
   end

   // ----------------------------------------------------------------
   // Setting ranges and selectors
   // ----------------------------------------------------------------
   always_comb begin
      hold_f = (ACCEL_HOLD_FREQUENCY > accel_pid_pkg::FREQ_HOLD_MAX) ?
               accel_pid_pkg::FREQ_HOLD_MAX : ACCEL_HOLD_FREQUENCY;
      hold_limit = 16'(((ACCEL_HOLD_DURATION > accel_pid_pkg::HOLD_DUR_MAX) ?
                   accel_pid_pkg::HOLD_DUR_MAX : ACCEL_HOLD_DURATION) * accel_pid_pkg::HOLD_UNIT_MS);
      kp = 6'(sat(48'(PID_CONFIG.proportional_gain), 48'(accel_pid_pkg::KP_MIN),
                  48'(accel_pid_pkg::KP_MAX)));
      ti = (PID_CONFIG.integral_time > accel_pid_pkg::TI_MAX) ?
           accel_pid_pkg::TI_MAX : PID_CONFIG.integral_time;
      td = (PID_CONFIG.derivative_time > accel_pid_pkg::TD_MAX) ?
           accel_pid_pkg::TD_MAX : PID_CONFIG.derivative_time;
      unique case (PID_CONFIG.feedback_source_select)
         accel_pid_pkg::FB_CURRENT: fb = ANALOG_IN.current_input;
         accel_pid_pkg::FB_VOLTAGE: fb = ANALOG_IN.voltage_input;
         accel_pid_pkg::FB_SERIAL: fb = ANALOG_IN.serial_feedback;
         accel_pid_pkg::FB_PULSE: fb = ANALOG_IN.pulse_feedback;
         accel_pid_pkg::FB_ARITH: fb = ANALOG_IN.arith_result;
         default: fb = '0;
      endcase
      unique case (PID_CONFIG.feedforward_select)
         accel_pid_pkg::FF_NONE: ff = '0;
         accel_pid_pkg::FF_VOLTAGE: ff = $signed({1'b0, ANALOG_IN.voltage_input});
         accel_pid_pkg::FF_CURRENT: ff = $signed({1'b0, ANALOG_IN.current_input});
         accel_pid_pkg::FF_BIPOLAR: ff = ANALOG_IN.bipolar_voltage_input;
      endcase
   end

   // ----------------------------------------------------------------
   // PID terms
   // ----------------------------------------------------------------
   always_comb begin
      dev = $signed({1'b0, SETPOINT}) - $signed({1'b0, fb});
      if (PID_CONFIG.deviation_invert) begin
         dev = -dev;
      end
      dev_abs = (dev < 0) ? -dev : dev;
      p_term = ($signed(48'(kp)) * 48'(dev)) / 48'sha;
      i_term = (ti == '0) ? 48'sh0 : acc / $signed(48'(ti) * 48'sh3e8);
      d_term = 48'(kp) * 48'(td) * 48'(dev - e_prev);
      u = p_term + i_term + d_term + 48'(ff);
      next_pct = u;
      if (u < 0) begin
         next_pct = (PID_CONFIG.pid_enable_select == accel_pid_pkg::PID_ON_INVERT) ? -u : 48'sd0;
      end
      // Inverted mode drops the variation limit, so the swing is bounded only by full scale.
      if (PID_CONFIG.pid_enable_select == accel_pid_pkg::PID_ON && PID_CONFIG.variation_range != '0) begin
         next_pct = sat(next_pct, 48'(SETPOINT) - 48'(PID_CONFIG.variation_range) * 48'sd10,
                        48'(SETPOINT) + 48'(PID_CONFIG.variation_range) * 48'sd10);
      end
      next_pct = sat(next_pct, 48'sd0, 48'(accel_pid_pkg::PCT_FULL));
      pid_freq = 16'((32'(pid_pct) * 32'(MAX_FREQ)) / 32'(accel_pid_pkg::PCT_FULL));
      pid_active = PID_CONFIG.pid_enable_select != accel_pid_pkg::PID_OFF && !PID_DISABLE_TERMINAL;
      target = pid_active ? pid_freq : FREQ_CMD;
   end

   // The accumulator is bounded so a long saturation cannot wind it past recovery.
   always_ff @(posedge REF_CLK) begin
      if (SRST || !pid_active || ti == '0) begin
         acc <= '0;
         e_prev <= '0;
         pid_pct <= '0;
      end else if (tick) begin
         acc <= sat(acc + 48'(kp) * 48'(dev), -48'sh10_0000_0000, 48'sh10_0000_0000);
         e_prev <= dev;
         pid_pct <= 16'(next_pct);
      end
   end

   // ----------------------------------------------------------------
   // Acceleration ramp with start-up hold
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         state <= ST_STOP;
         FREQ_OUT <= accel_pid_pkg::FREQ_RESET;
         held <= 1'b0;
         hold_ms <= '0;
      end else if (!START) begin
         state <= ST_STOP;
         FREQ_OUT <= accel_pid_pkg::FREQ_RESET;
         held <= 1'b0;
         hold_ms <= '0;
      end else if (tick) begin
         unique case (state)
            ST_STOP: begin
               state <= ST_RAMP;
            end
            ST_RAMP: begin
               // The hold depends only on frequency, never on the curve shape in use.
               if (!held && hold_f != '0 && FREQ_OUT < hold_f && target > hold_f &&
                   17'(FREQ_OUT) + 17'(ACCEL_STEP) >= 17'(hold_f)) begin
                  FREQ_OUT <= hold_f;
                  state <= ST_HOLD;
                  hold_ms <= '0;
               end else if (target <= FREQ_OUT || 17'(FREQ_OUT) + 17'(ACCEL_STEP) >= 17'(target)) begin
                  FREQ_OUT <= target;
               end else begin
                  FREQ_OUT <= FREQ_OUT + ACCEL_STEP;
               end
            end
            ST_HOLD: begin
               if (hold_ms + 16'h0001 >= hold_limit) begin
                  held <= 1'b1;
                  state <= ST_RAMP;
               end
               hold_ms <= hold_ms + 16'h0001;
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK) begin
      HOLD_ACTIVE <= !SRST && START && state == ST_HOLD;
      ACTIVE_CURVE <= SRST ? 2'h0 : ACCEL_CURVE_SELECT;
   end

   // ----------------------------------------------------------------
   // Monitors and comparison outputs
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         PROCESS_VALUE <= '0;
         DEVIATION_ALARM_OUTPUT <= 1'b0;
         FEEDBACK_COMPARE_OUTPUT <= 1'b0;
      end else begin
         PROCESS_VALUE <= 20'((32'(fb) * 32'(sat(48'(PID_CONFIG.feedback_scale),
                          48'(accel_pid_pkg::FB_SCALE_MIN), 48'(accel_pid_pkg::FB_SCALE_MAX)))) / 32'd100);
         DEVIATION_ALARM_OUTPUT <= 32'(dev_abs) >
                                   32'(PID_CONFIG.deviation_alarm_level) * 32'(accel_pid_pkg::PCT_TENTH);
         if (32'(fb) >= 32'(PID_CONFIG.feedback_compare_on_level) * 32'(accel_pid_pkg::PCT_TENTH)) begin
            FEEDBACK_COMPARE_OUTPUT <= 1'b1;
         end else if (32'(fb) <= 32'(PID_CONFIG.feedback_compare_off_level) * 32'(accel_pid_pkg::PCT_TENTH)) begin
            FEEDBACK_COMPARE_OUTPUT <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence hold_entry;
      START && tick && state == ST_RAMP ##1 state == ST_HOLD;
   endsequence

   sequence ramp_tick;
      START && tick && state == ST_RAMP;
   endsequence

   chk_hold_level: assert property (@(posedge REF_CLK) disable iff (SRST)
      hold_entry |-> FREQ_OUT == hold_f [*2])
      else $error("Output left the hold frequency during the hold.");
   chk_hold_time: assert property (@(posedge REF_CLK) disable iff (SRST)
      state == ST_HOLD |-> hold_ms < hold_limit || hold_limit == '0)
      else $error("Hold lasted longer than its duration.");
   chk_resume_ramp: assert property (@(posedge REF_CLK) disable iff (SRST)
      START && tick && state == ST_HOLD && hold_ms + 16'h0001 >= hold_limit |=> state == ST_RAMP && held)
      else $error("Acceleration did not resume after the hold.");
   chk_pid_off: assert property (@(posedge REF_CLK) disable iff (SRST)
      PID_CONFIG.pid_enable_select == accel_pid_pkg::PID_OFF |-> target == FREQ_CMD)
      else $error("PID steered the output while switched off.");
   chk_bypass: assert property (@(posedge REF_CLK) disable iff (SRST)
      PID_DISABLE_TERMINAL |-> !pid_active ##1 pid_pct == '0)
      else $error("PID stayed active under the disable terminal.");
   chk_neg_clamp: assert property (@(posedge REF_CLK) disable iff (SRST)
      pid_active && ti != '0 && tick && u < 0 && PID_CONFIG.pid_enable_select == accel_pid_pkg::PID_ON &&
      PID_CONFIG.variation_range == '0 |=> pid_pct == '0)
      else $error("Negative PID result was not clamped to zero.");
   chk_var_limit: assert property (@(posedge REF_CLK) disable iff (SRST)
      pid_active && ti != '0 && tick && PID_CONFIG.pid_enable_select == accel_pid_pkg::PID_ON &&
      PID_CONFIG.variation_range != '0 |=>
      32'(pid_pct) <= 32'($past(SETPOINT)) + 32'($past(PID_CONFIG.variation_range)) * 32'd10)
      else $error("PID output exceeded the variation range.");
   chk_dev_alarm: assert property (@(posedge REF_CLK) disable iff (SRST)
      32'(dev_abs) > 32'(PID_CONFIG.deviation_alarm_level) * 32'd10 |=> DEVIATION_ALARM_OUTPUT)
      else $error("Deviation alarm missed a large deviation.");
   chk_fbv_hyst: assert property (@(posedge REF_CLK) disable iff (SRST)
      $past(FEEDBACK_COMPARE_OUTPUT) && 32'($past(fb)) > 32'($past(PID_CONFIG.feedback_compare_off_level)) * 32'd10
      |-> FEEDBACK_COMPARE_OUTPUT)
      else $error("Feedback compare output dropped above the off level.");

   // ----------------------------------------------------------------
   // Ramp and hold checks
   // ----------------------------------------------------------------
   chk_hold_freeze: assert property (
      START && state == ST_HOLD |=> FREQ_OUT == $past(FREQ_OUT))
      else $error("Output moved during the hold.");
   chk_hold_flag: assert property (
      START && state == ST_HOLD |=> HOLD_ACTIVE)
      else $error("Hold flag low during the hold.");
   chk_ramp_step: assert property (
      ramp_tick ##0 held && 17'(FREQ_OUT) + 17'(ACCEL_STEP) < 17'(target) |=>
      FREQ_OUT == $past(FREQ_OUT) + $past(ACCEL_STEP))
      else $error("Ramp did not rise by one step.");
   chk_ramp_land: assert property (
      ramp_tick ##0 target <= FREQ_OUT |=> FREQ_OUT == $past(target))
      else $error("Output did not settle on the target.");
   chk_no_overshoot: assert property (
      ramp_tick ##0 !held && hold_f != '0 && FREQ_OUT < hold_f && target > hold_f |=>
      FREQ_OUT <= $past(hold_f))
      else $error("Ramp passed the hold frequency.");
   chk_hold_once: assert property (
      held && state == ST_RAMP |=> state != ST_HOLD)
      else $error("Hold entered twice in one run.");
   chk_curve_echo: assert property (
      !SRST |=> ACTIVE_CURVE == $past(ACCEL_CURVE_SELECT))
      else $error("Curve echo does not follow the selection.");
   chk_stop_zero: assert property (
      !START |=> FREQ_OUT == '0 && state == ST_STOP)
      else $error("Output not cleared while stopped.");

   // ----------------------------------------------------------------
   // PID checks
   // ----------------------------------------------------------------
   chk_bypass_target: assert property (
      PID_DISABLE_TERMINAL |-> target == FREQ_CMD)
      else $error("Bypass did not select the normal command.");
   chk_invert_out: assert property (
      pid_active && ti != '0 && tick && u < 0 && -u <= $signed(48'(accel_pid_pkg::PCT_FULL)) &&
      PID_CONFIG.pid_enable_select == accel_pid_pkg::PID_ON_INVERT |=> 48'(pid_pct) == -$past(u))
      else $error("Negative result was not inverted.");
   chk_pct_full: assert property (
      pid_pct <= accel_pid_pkg::PCT_FULL)
      else $error("PID output above full scale.");
   chk_invert_dev: assert property (
      PID_CONFIG.deviation_invert |->
      dev == $signed({1'b0, fb}) - $signed({1'b0, SETPOINT}))
      else $error("Deviation sign was not inverted.");
   chk_fb_select: assert property (
      PID_CONFIG.feedback_source_select == accel_pid_pkg::FB_ARITH |-> fb == ANALOG_IN.arith_result)
      else $error("Arithmetic feedback not selected.");
   chk_ff_none: assert property (
      PID_CONFIG.feedforward_select == accel_pid_pkg::FF_NONE |-> ff == '0)
      else $error("Feed forward added while disabled.");

   // ----------------------------------------------------------------
   // Comparator and monitor checks
   // ----------------------------------------------------------------
   chk_alarm_clear: assert property (
      32'(dev_abs) <= 32'(PID_CONFIG.deviation_alarm_level) * 32'(accel_pid_pkg::PCT_TENTH) |=> !DEVIATION_ALARM_OUTPUT)
      else $error("Deviation alarm raised at or below the level.");
   chk_fbv_set: assert property (
      32'(fb) >= 32'(PID_CONFIG.feedback_compare_on_level) * 32'(accel_pid_pkg::PCT_TENTH) |=> FEEDBACK_COMPARE_OUTPUT)
      else $error("Feedback compare output not set at the on level.");
   chk_fbv_clear: assert property (
      32'(fb) < 32'(PID_CONFIG.feedback_compare_on_level) * 32'(accel_pid_pkg::PCT_TENTH) &&
      32'(fb) <= 32'(PID_CONFIG.feedback_compare_off_level) * 32'(accel_pid_pkg::PCT_TENTH) |=> !FEEDBACK_COMPARE_OUTPUT)
      else $error("Feedback compare output not cleared at the off level.");
   chk_pv_scale: assert property (
      PID_CONFIG.feedback_scale == 14'h0064 |=> PROCESS_VALUE == 20'($past(fb)))
      else $error("Unit scale changed the process value.");
endmodule

// >>> verilog/accel_pid_pkg.sv
// Shared constants and carrier types for the acceleration hold and process PID block.
package accel_pid_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_TIME_US = 1000;
   localparam int TICK_CYCLES = TICK_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int HOLD_UNIT_MS = 100;
   // ----------------------------------------------------------------
   // Scaling and limits
   // ----------------------------------------------------------------
   localparam logic [15:0] PCT_FULL = 16'h2710;
   localparam logic [15:0] PCT_TENTH = 16'h000a;
   localparam logic [15:0] FREQ_HOLD_MAX = 16'h9c40;
   localparam logic [9:0] HOLD_DUR_MAX = 10'h258;
   localparam logic [5:0] KP_MIN = 6'h02;
   localparam logic [5:0] KP_MAX = 6'h32;
   localparam logic [15:0] TI_MAX = 16'h8ca0;
   localparam logic [13:0] TD_MAX = 14'h2710;
   localparam logic [13:0] FB_SCALE_MIN = 14'h0001;
   localparam logic [13:0] FB_SCALE_MAX = 14'h270f;
   localparam logic [15:0] FREQ_RESET = 16'h0000;
   // ----------------------------------------------------------------
   // Setting codes
   // ----------------------------------------------------------------
   localparam logic [1:0] PID_OFF = 2'h0;
   localparam logic [1:0] PID_ON = 2'h1;
   localparam logic [1:0] PID_ON_INVERT = 2'h2;
   localparam logic [3:0] FB_CURRENT = 4'h0;
   localparam logic [3:0] FB_VOLTAGE = 4'h1;
   localparam logic [3:0] FB_SERIAL = 4'h2;
   localparam logic [3:0] FB_PULSE = 4'h3;
   localparam logic [3:0] FB_ARITH = 4'ha;
   localparam logic [1:0] FF_NONE = 2'h0;
   localparam logic [1:0] FF_VOLTAGE = 2'h1;
   localparam logic [1:0] FF_CURRENT = 2'h2;
   localparam logic [1:0] FF_BIPOLAR = 2'h3;
   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] pid_enable_select;
      logic [5:0] proportional_gain;
      logic [15:0] integral_time;
      logic [13:0] derivative_time;
      logic [13:0] feedback_scale;
      logic [3:0] feedback_source_select;
      logic deviation_invert;
      logic [9:0] variation_range;
      logic [1:0] feedforward_select;
      logic [9:0] deviation_alarm_level;
      logic [9:0] feedback_compare_off_level;
      logic [9:0] feedback_compare_on_level;
   } pid_cfg_t;
   typedef struct packed {
      logic [15:0] current_input;
      logic [15:0] voltage_input;
      logic [15:0] serial_feedback;
      logic [15:0] pulse_feedback;
      logic [15:0] arith_result;
      logic signed [16:0] bipolar_voltage_input;
   } analog_in_t;
endpackage
